// >>> core/accel_cfg_pkg.sv
// Shared constants for the acceleration configuration register bank.
package accel_cfg_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FACTORY_CFG  = 8'h30;
  localparam logic [7:0] ADDR_SELFTEST_REF = 8'h31;
  localparam logic [7:0] ADDR_USER_CFG     = 8'h32;
  localparam logic [7:0] ADDR_RESULT_LOW   = 8'h33;
  localparam logic [7:0] ADDR_RESULT_HIGH  = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FCT_ZERO_BIT      = 7;
  localparam int FCT_PCM_BIT       = 6;
  localparam int FCT_AXIS_BIT      = 5;
  localparam int FCT_RANGE_MSB     = 4;
  localparam int FCT_RANGE_LSB     = 0;
  localparam int USER_LPF_MSB      = 7;
  localparam int USER_LPF_LSB      = 4;
  localparam int USER_UNSIGNED_BIT = 3;
  localparam int USER_OC_MSB       = 2;
  localparam int USER_OC_LSB       = 0;

  // ----------------------------------------------------------------
  // Reset values and fixed answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  FACTORY_CFG_RESET  = 8'h00;
  localparam logic [7:0]  SELFTEST_REF_RESET = 8'h00;
  localparam logic [7:0]  USER_CFG_RESET     = 8'h00;
  localparam logic [15:0] RESULT_RESET       = 16'h0000;
  localparam logic [7:0]  UNMAPPED_DATA      = 8'h00;
  localparam logic [15:0] SIGN_FLIP          = 16'h8000;

  // ----------------------------------------------------------------
  // Full-scale range codes
  // ----------------------------------------------------------------
  localparam logic [4:0] RANGE_25G  = 5'h06;
  localparam logic [4:0] RANGE_125G = 5'h14;
  localparam logic [4:0] RANGE_187G = 5'h16;
  localparam logic [4:0] RANGE_250G = 5'h19;
  localparam logic [4:0] RANGE_375G = 5'h1C;

  // ----------------------------------------------------------------
  // Low-pass and offset-cancellation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] LPF_180_P2  = 4'h0;
  localparam logic [3:0] LPF_325_P3  = 4'h6;
  localparam logic [3:0] LPF_400_P3  = 4'h8;
  localparam logic [3:0] LPF_400_P4  = 4'h9;
  localparam logic [3:0] LPF_800_P4  = 4'hB;
  localparam logic [3:0] LPF_1200_P4 = 4'hE;
  localparam logic [2:0] OC_HPF_RATE   = 3'h0;
  localparam logic [2:0] OC_HPF_NORATE = 3'h1;
  localparam logic [2:0] OC_NONE_A     = 3'h6;
  localparam logic [2:0] OC_NONE_B     = 3'h7;

endpackage

// >>> core/accel_sample_format.sv
// Signed or unsigned encoding of one acceleration sample.
`timescale 1ns/1ps
module accel_sample_format #(
  parameter int WIDTH = 16
) (
  // Sample in
  input  wire logic [WIDTH-1:0] raw_in,
  input  wire logic             unsigned_sel_in,
  // Encoded sample out
  output logic      [WIDTH-1:0] coded_out
);

  // Offset binary is two's complement with the sign bit flipped.
  always_comb begin
    if (unsigned_sel_in) begin
      coded_out = raw_in ^ accel_cfg_pkg::SIGN_FLIP[WIDTH-1:0];
    end else begin
      coded_out = raw_in;
    end
  end

endmodule

// >>> core/accel_pcm_out.sv
// First-order pulse-code modulator for the acceleration output pin.
`timescale 1ns/1ps
module accel_pcm_out #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // Control and level
  input  wire logic             enable_in,
  input  wire logic [WIDTH-1:0] level_in,
  // Pin
  output logic                  pcm_out
);

  logic [WIDTH:0] acc_q;

  // Pulse density follows the unsigned level; disabled means a hard low.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q   <= '0;
      pcm_out <= 1'b0;
    end else if (!enable_in) begin
      acc_q   <= '0;
      pcm_out <= 1'b0;
    end else begin
      acc_q   <= {1'b0, acc_q[WIDTH-1:0]} + {1'b0, level_in};
      pcm_out <= acc_q[WIDTH];
    end
  end

endmodule

// >>> core/accel_config_register_bank.sv
// Acceleration configuration and result register bank with command port.
//
// Contract
// R1: Factory output-enable one drives modulated pin; zero holds the pin low.
// R2: Read-only factory axis bit: zero means X axis, one means Z axis.
// R3: Five-bit range code: 06h 25g, 14h 125g, 16h 187g, 19h 250g, 1Ch 375g.
// R4: Factory register is OTP-backed, user read-only, bit 7 zero, defaults zero.
// R5: Self-test reference byte; active self-test compares readings against it.
// R6: Low-pass codes 0,6,8,9,B,E select filters; all other codes reserved.
// R7: Format bit one gives unsigned results, zero gives signed results.
// R8: Offset mode 0 HPF with rate limit, 1 without, 6/7 none, rest reserved.
// R9: User configuration at 32h is read/write and defaults to zero.
// R10: Result low byte 33h, high byte 34h; low read returns both bytes.
// R11: Reading one result byte never latches the other one.
// R12: Master should take full samples from the low-byte read response.
// R13: Writes to read-only registers change nothing but still answer contents.
// R14: Once periodic collection is enabled, register writes are ignored.
// R15: Configuration changes apply to samples produced after the write; the pin level decodes the held sample with a new format bit at once.
`timescale 1ns/1ps
module accel_config_register_bank #(
  parameter int DATA_W       = 16,
  parameter int ST_TOLERANCE = 16
) (
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  // Register command port
  input  wire logic              cmd_valid_in,
  input  wire logic              cmd_write_in,
  input  wire logic [7:0]        cmd_addr_in,
  input  wire logic [7:0]        cmd_wdata_in,
  output logic                   rsp_valid_out,
  output logic      [15:0]       rsp_data_out,
  // Factory OTP mirror load
  input  wire logic              otp_load_in,
  input  wire logic [7:0]        otp_factory_cfg_in,
  input  wire logic [7:0]        otp_selftest_ref_in,
  // Mode inputs
  input  wire logic              periodic_collect_enable_in,
  input  wire logic              selftest_active_in,
  // Sample path
  input  wire logic              sample_valid_in,
  input  wire logic [DATA_W-1:0] sample_raw_in,
  // Configuration to the filter datapath
  output logic      [3:0]        lowpass_select_out,
  output logic                   lowpass_reserved_out,
  output logic                   unsigned_format_sel_out,
  output logic      [2:0]        offset_cancel_mode_out,
  output logic                   highpass_enable_out,
  output logic                   rate_limit_enable_out,
  output logic                   offset_reserved_out,
  // Factory information and user configuration
  output logic      [4:0]        full_scale_code_out,
  output logic                   range_code_valid_out,
  output logic                   axis_is_z_out,
  output logic      [7:0]        factory_cfg_out,
  output logic      [7:0]        selftest_ref_value_out,
  output logic      [7:0]        user_cfg_out,
  // Self-test result
  output logic                   selftest_done_out,
  output logic                   selftest_pass_out,
  // Pulse-code pin
  output logic                   pcm_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]        factory_accel_config_q;
  logic [7:0]        selftest_deflection_ref_q;
  logic [7:0]        user_accel_config_q;
  logic [DATA_W-1:0] accel_sample_bits_q;
  logic [DATA_W-1:0] coded_sample;
  logic              user_write;
  logic              pcm_enable;

  // ----------------------------------------------------------------
  // Factory registers
  // ----------------------------------------------------------------
  // Only the OTP mirror load reaches these; command writes never do.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      factory_accel_config_q <= accel_cfg_pkg::FACTORY_CFG_RESET; // R4
    end else if (otp_load_in) begin
      factory_accel_config_q <= {1'b0, otp_factory_cfg_in[6:0]}; // R4
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      selftest_deflection_ref_q <= accel_cfg_pkg::SELFTEST_REF_RESET;
    end else if (otp_load_in) begin
      selftest_deflection_ref_q <= otp_selftest_ref_in; // R5
    end
  end

  // ----------------------------------------------------------------
  // User configuration register
  // ----------------------------------------------------------------
  // Frozen during periodic collection so the running integrity check holds.
  assign user_write = cmd_valid_in && cmd_write_in && !periodic_collect_enable_in // R14
                      && (cmd_addr_in == accel_cfg_pkg::ADDR_USER_CFG);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      user_accel_config_q <= accel_cfg_pkg::USER_CFG_RESET; // R9
    end else if (user_write) begin
      user_accel_config_q <= cmd_wdata_in; // R9
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign lowpass_select_out =
    user_accel_config_q[accel_cfg_pkg::USER_LPF_MSB:accel_cfg_pkg::USER_LPF_LSB];
  assign unsigned_format_sel_out = user_accel_config_q[accel_cfg_pkg::USER_UNSIGNED_BIT];
  assign offset_cancel_mode_out =
    user_accel_config_q[accel_cfg_pkg::USER_OC_MSB:accel_cfg_pkg::USER_OC_LSB];

  always_comb begin
    unique case (lowpass_select_out)
      accel_cfg_pkg::LPF_180_P2,
      accel_cfg_pkg::LPF_325_P3,
      accel_cfg_pkg::LPF_400_P3,
      accel_cfg_pkg::LPF_400_P4,
      accel_cfg_pkg::LPF_800_P4,
      accel_cfg_pkg::LPF_1200_P4: lowpass_reserved_out = 1'b0; // R6
      default:                    lowpass_reserved_out = 1'b1; // R6
    endcase
  end

  always_comb begin
    highpass_enable_out   = 1'b0;
    rate_limit_enable_out = 1'b0;
    offset_reserved_out   = 1'b0;
    unique case (offset_cancel_mode_out)
      accel_cfg_pkg::OC_HPF_RATE: begin
        highpass_enable_out   = 1'b1; // R8
        rate_limit_enable_out = 1'b1; // R8
      end
      accel_cfg_pkg::OC_HPF_NORATE: begin
        highpass_enable_out = 1'b1; // R8
      end
      accel_cfg_pkg::OC_NONE_A,
      accel_cfg_pkg::OC_NONE_B: begin
        highpass_enable_out = 1'b0; // R8
      end
      default: begin
        offset_reserved_out = 1'b1; // R8
      end
    endcase
  end

  assign full_scale_code_out =
    factory_accel_config_q[accel_cfg_pkg::FCT_RANGE_MSB:accel_cfg_pkg::FCT_RANGE_LSB];
  assign axis_is_z_out = factory_accel_config_q[accel_cfg_pkg::FCT_AXIS_BIT]; // R2
  assign pcm_enable    = factory_accel_config_q[accel_cfg_pkg::FCT_PCM_BIT];

  always_comb begin
    unique case (full_scale_code_out)
      accel_cfg_pkg::RANGE_25G,
      accel_cfg_pkg::RANGE_125G,
      accel_cfg_pkg::RANGE_187G,
      accel_cfg_pkg::RANGE_250G,
      accel_cfg_pkg::RANGE_375G: range_code_valid_out = 1'b1; // R3
      default:                   range_code_valid_out = 1'b0; // R3
    endcase
  end

  assign factory_cfg_out        = factory_accel_config_q;
  assign selftest_ref_value_out = selftest_deflection_ref_q;
  assign user_cfg_out           = user_accel_config_q;

  // ----------------------------------------------------------------
  // Acceleration result
  // ----------------------------------------------------------------
  // The format bit is sampled at capture, so a new setting only recodes stored samples
  // that arrive after the write has landed; the pin level decodes the held sample with the new bit at once.
  accel_sample_format #(
    .WIDTH           (DATA_W)
  ) u_format (
    .raw_in          (sample_raw_in),
    .unsigned_sel_in (unsigned_format_sel_out), // R15
    .coded_out       (coded_sample)
  );

  // Updates on every sample regardless of reads; no shadow copy is kept.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      accel_sample_bits_q <= accel_cfg_pkg::RESULT_RESET[DATA_W-1:0];
    end else if (sample_valid_in) begin
      accel_sample_bits_q <= coded_sample; // R7 R11
    end
  end

  // ----------------------------------------------------------------
  // Command response
  // ----------------------------------------------------------------
  // Every command answers one cycle later; writes that do not execute
  // still report current contents, unmapped addresses report zero.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= 16'h0000;
    end else begin
      rsp_valid_out <= cmd_valid_in;
      if (cmd_valid_in) begin
        unique case (cmd_addr_in)
          accel_cfg_pkg::ADDR_FACTORY_CFG:  rsp_data_out <= {8'h00, factory_accel_config_q}; // R13
          accel_cfg_pkg::ADDR_SELFTEST_REF: rsp_data_out <= {8'h00, selftest_deflection_ref_q};
          accel_cfg_pkg::ADDR_USER_CFG: begin
            if (user_write) begin
              rsp_data_out <= {8'h00, cmd_wdata_in};
            end else begin
              rsp_data_out <= {8'h00, user_accel_config_q};
            end
          end
          accel_cfg_pkg::ADDR_RESULT_LOW:  rsp_data_out <= accel_sample_bits_q; // R10 R12
          accel_cfg_pkg::ADDR_RESULT_HIGH: rsp_data_out <= {8'h00, accel_sample_bits_q[15:8]}; // R10
          default: rsp_data_out <= {8'h00, accel_cfg_pkg::UNMAPPED_DATA};
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-test comparison
  // ----------------------------------------------------------------
  // Compared on the raw signed reading so the output format cannot skew it.
  logic signed [DATA_W:0] st_diff;
  logic        [DATA_W:0] st_mag;

  always_comb begin
    st_diff = $signed({sample_raw_in[DATA_W-1], sample_raw_in})
              - $signed({{(DATA_W-7){1'b0}}, selftest_deflection_ref_q});
    st_mag  = st_diff[DATA_W] ? (DATA_W+1)'(0) - st_diff : st_diff;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      selftest_done_out <= 1'b0;
      selftest_pass_out <= 1'b0;
    end else if (selftest_active_in && sample_valid_in) begin
      selftest_done_out <= 1'b1; // R5
      selftest_pass_out <= (st_mag <= (DATA_W+1)'(ST_TOLERANCE)); // R5
    end else if (!selftest_active_in) begin
      selftest_done_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pulse-code output
  // ----------------------------------------------------------------
  accel_pcm_out #(
    .WIDTH      (DATA_W)
  ) u_pcm (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .enable_in  (pcm_enable), // R1
    .level_in   (accel_sample_bits_q ^ (unsigned_format_sel_out ? 16'h0000 :
                                        accel_cfg_pkg::SIGN_FLIP)),
    .pcm_out    (pcm_out)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_pcm_held_low: assert property (!pcm_enable [*2] |-> !pcm_out) // R1
    else $error("pulse-code pin not low while disabled");
  a_axis_bit_map: assert property (otp_load_in // R2
      |=> axis_is_z_out == $past(otp_factory_cfg_in[accel_cfg_pkg::FCT_AXIS_BIT]))
    else $error("axis indication does not follow factory bit");
  a_factory_top_zero: assert property (factory_accel_config_q[7] == 1'b0) // R4
    else $error("factory register bit 7 is not zero");
  a_factory_ro_write: assert property (cmd_valid_in && cmd_write_in && !otp_load_in // R13
      && cmd_addr_in == 8'h30 |=> $stable(factory_accel_config_q))
    else $error("command write changed factory register");
  a_user_write_lands: assert property (cmd_valid_in && cmd_write_in // R9
      && cmd_addr_in == 8'h32 && !periodic_collect_enable_in
      |=> user_accel_config_q == $past(cmd_wdata_in))
    else $error("user configuration write lost");
  a_collect_freezes: assert property (periodic_collect_enable_in // R14
      |=> $stable(user_accel_config_q))
    else $error("user configuration changed during periodic collection");
  a_low_read_both: assert property (cmd_valid_in && cmd_addr_in == 8'h33 // R10
      |=> rsp_valid_out && rsp_data_out == $past(accel_sample_bits_q))
    else $error("low-byte read did not return both bytes");
  a_unmapped_zero: assert property (cmd_valid_in && cmd_addr_in > 8'h34
      |=> rsp_valid_out && rsp_data_out == 16'h0000)
    else $error("unmapped address did not answer zero");
  a_format_capture: assert property (sample_valid_in ##1 1'b1 // R7
      |-> accel_sample_bits_q == ($past(sample_raw_in)
          ^ ($past(unsigned_format_sel_out) ? 16'h8000 : 16'h0000)))
    else $error("captured sample has wrong encoding");
  a_range_decode: assert property (range_code_valid_out == // R3
      (full_scale_code_out inside {5'h06, 5'h14, 5'h16, 5'h19, 5'h1C}))
    else $error("range code validity wrong");
  a_lowpass_decode: assert property (lowpass_reserved_out != // R6
      (lowpass_select_out inside {4'h0, 4'h6, 4'h8, 4'h9, 4'hB, 4'hE}))
    else $error("low-pass reserved flag wrong");

endmodule

// >>> tb/bus_master_model.sv
// Register command master model driving the bank's command port.
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input  wire logic        ref_clk_in,
  // Response from the bank
  input  wire logic        rsp_valid_in,
  input  wire logic [15:0] rsp_data_in,
  // Command to the bank
  output logic             cmd_valid_out,
  output logic             cmd_write_out,
  output logic      [7:0]  cmd_addr_out,
  output logic      [7:0]  cmd_wdata_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_addr_out  = 8'h00;
    cmd_wdata_out = 8'h00;
  end

  // Released lines are inverted so a stale value can never pass as fresh.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [15:0] r, output logic ok);
    @(posedge ref_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= w;
    cmd_addr_out  <= a;
    cmd_wdata_out <= d;
    @(posedge ref_clk_in);
    cmd_valid_out <= 1'b0;
    cmd_write_out <= ~w;
    cmd_addr_out  <= ~a;
    cmd_wdata_out <= ~d;
    @(posedge ref_clk_in);
    ok = rsp_valid_in;
    r  = rsp_data_in;
  endtask
endmodule

// >>> tb/accel_config_register_bank_tb.sv
// Self-checking bench for the acceleration register bank.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module accel_config_register_bank_tb;
  logic        ref_clk_in;
  logic        rst_in;
  logic        cmd_valid, cmd_write, rsp_valid;
  logic [7:0]  cmd_addr, cmd_wdata;
  logic [15:0] rsp_data;
  logic        otp_load_in, periodic_in, st_active_in, sample_valid_in;
  logic [7:0]  otp_fct_in, otp_st_in;
  logic [7:0]  fct_cfg, st_ref, usr_cfg;
  logic [15:0] sample_raw_in;
  logic [3:0]  lowpass_select;
  logic [2:0]  oc;
  logic [4:0]  fs_code;
  logic        lpf_rsv, uns, hpf, rate, oc_rsv, fs_ok, axis_z, st_done, st_pass, pcm;
  int          miscompares = 0;
  int          checks_done = 0;

  accel_config_register_bank accel_config_register_bank_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .otp_load_in(otp_load_in),
    .otp_factory_cfg_in(otp_fct_in), .otp_selftest_ref_in(otp_st_in),
    .periodic_collect_enable_in(periodic_in), .selftest_active_in(st_active_in),
    .sample_valid_in(sample_valid_in), .sample_raw_in(sample_raw_in),
    .lowpass_select_out(lowpass_select), .lowpass_reserved_out(lpf_rsv),
    .unsigned_format_sel_out(uns), .offset_cancel_mode_out(oc),
    .highpass_enable_out(hpf), .rate_limit_enable_out(rate),
    .offset_reserved_out(oc_rsv), .full_scale_code_out(fs_code),
    .range_code_valid_out(fs_ok), .axis_is_z_out(axis_z), .factory_cfg_out(fct_cfg),
    .selftest_ref_value_out(st_ref), .user_cfg_out(usr_cfg), .selftest_done_out(st_done),
    .selftest_pass_out(st_pass), .pcm_out(pcm));

  bus_master_model bus_master_model_i (
    .ref_clk_in(ref_clk_in), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
    .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
    .cmd_addr_out(cmd_addr), .cmd_wdata_out(cmd_wdata));

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A missing answer ends the run, since later checks would only cascade.
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [15:0] e);
    logic [15:0] r;
    logic        ok;
    bus_master_model_i.xfer(w, a, d, r, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] rsp_valid_out exp 1 got %0h", ok);
      conclude();
    end else begin
      `CHK("rsp_data_out", e, r)
    end
  endtask

  task automatic push(input logic [15:0] raw);
    @(posedge ref_clk_in);
    sample_valid_in <= 1'b1;
    sample_raw_in   <= raw;
    @(posedge ref_clk_in);
    sample_valid_in <= 1'b0;
    sample_raw_in   <= ~raw;
    #1;
  endtask

  task automatic load(input logic [7:0] f, input logic [7:0] s);
    @(posedge ref_clk_in);
    otp_load_in <= 1'b1;
    otp_fct_in  <= f;
    otp_st_in   <= s;
    @(posedge ref_clk_in);
    otp_load_in <= 1'b0;
    otp_fct_in  <= ~f;
    otp_st_in   <= ~s;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    op(1'b0, 8'h30, 8'h00, 16'h0000);
    op(1'b0, 8'h32, 8'h00, 16'h0000);
    op(1'b0, 8'h33, 8'h00, 16'h0000);
    op(1'b0, 8'h34, 8'h00, 16'h0000);
    `CHK("rate_limit_enable_out", 1'b1, rate)
  endtask

  task automatic t_factory();
    logic [4:0] codes[6] = '{5'h06, 5'h14, 5'h16, 5'h19, 5'h1C, 5'h07};
    load(8'hFF, 8'h5A);
    op(1'b0, 8'h30, 8'h00, 16'h007F);
    op(1'b1, 8'h30, 8'h00, 16'h007F);
    op(1'b1, 8'h31, 8'h00, 16'h005A);
    op(1'b0, 8'h31, 8'h00, 16'h005A);
    `CHK("axis_is_z_out", 1'b1, axis_z)
    `CHK("factory_cfg_out", 8'h7F, fct_cfg)
    `CHK("selftest_ref_value_out", 8'h5A, st_ref)
    foreach (codes[i]) begin
      load({3'b000, codes[i]}, 8'h00);
      `CHK("axis_is_z_out", 1'b0, axis_z)
      `CHK("full_scale_code_out", codes[i], fs_code)
      `CHK("range_code_valid_out", (i < 5), fs_ok)
    end
  endtask

  task automatic t_user();
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      d = {i[3:0], i[0], i[2:0]};
      op(1'b1, 8'h32, d, {8'h00, d});
      `CHK("user_cfg_out", d, usr_cfg)
      `CHK("lowpass_select_out", i[3:0], lowpass_select)
      `CHK("lowpass_reserved_out", !(i inside {0, 6, 8, 9, 11, 14}), lpf_rsv)
      `CHK("unsigned_format_sel_out", i[0], uns)
      `CHK("offset_cancel_mode_out", i[2:0], oc)
      `CHK("highpass_enable_out", (i[2:0] < 2), hpf)
      `CHK("rate_limit_enable_out", (i[2:0] == 0), rate)
      `CHK("offset_reserved_out", (i[2:0] inside {[2:5]}), oc_rsv)
    end
    op(1'b0, 8'h32, 8'h00, 16'h00FF);
  endtask

  task automatic t_data();
    op(1'b1, 8'h32, 8'h00, 16'h0000);
    push(16'h1234);
    op(1'b0, 8'h33, 8'h00, 16'h1234);
    op(1'b0, 8'h34, 8'h00, 16'h0012);
    op(1'b1, 8'h32, 8'h08, 16'h0008);
    op(1'b0, 8'h33, 8'h00, 16'h1234);
    push(16'h1234);
    op(1'b0, 8'h33, 8'h00, 16'h9234);
    op(1'b0, 8'h34, 8'h00, 16'h0092);
    push(16'h5678);
    op(1'b0, 8'h33, 8'h00, 16'hD678);
    op(1'b1, 8'h33, 8'hFF, 16'hD678);
    op(1'b1, 8'h34, 8'hFF, 16'h00D6);
    op(1'b0, 8'h40, 8'h00, 16'h0000);
    op(1'b1, 8'h40, 8'hFF, 16'h0000);
  endtask

  task automatic t_freeze();
    @(posedge ref_clk_in);
    periodic_in <= 1'b1;
    op(1'b1, 8'h32, 8'hE6, 16'h0008);
    op(1'b0, 8'h32, 8'h00, 16'h0008);
    `CHK("user_cfg_out", 8'h08, usr_cfg)
    @(posedge ref_clk_in);
    periodic_in <= 1'b0;
  endtask

  // Offset-binary level C000h must give three ones in every four cycles.
  task automatic t_pcm();
    int n;
    load(8'h00, 8'h00);
    push(16'h4000);
    n = 0;
    repeat (64) begin
      @(posedge ref_clk_in);
      n += (pcm === 1'b1);
    end
    `CHK("pcm_out ones", 0, n)
    load(8'h40, 8'h00);
    // The accumulator and pin register take three edges to reach the steady pattern.
    repeat (3) @(posedge ref_clk_in);
    n = 0;
    repeat (64) begin
      @(posedge ref_clk_in);
      n += (pcm === 1'b1);
    end
    `CHK("pcm_out density", 1'b1, (n >= 47 && n <= 49))
  endtask

  task automatic t_selftest();
    logic [15:0] raws[5] = '{16'h0048, 16'h0050, 16'h0051, 16'h0030, 16'h002F};
    logic        exp[5]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    load(8'h00, 8'h40);
    @(posedge ref_clk_in);
    st_active_in <= 1'b1;
    foreach (raws[i]) begin
      push(raws[i]);
      `CHK("selftest_done_out", 1'b1, st_done)
      `CHK("selftest_pass_out", exp[i], st_pass)
    end
    @(posedge ref_clk_in);
    st_active_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    `CHK("selftest_done_out", 1'b0, st_done)
  endtask

  initial begin
    rst_in          = 1'b1;
    otp_load_in     = 1'b0;
    otp_fct_in      = 8'h00;
    otp_st_in       = 8'h00;
    periodic_in     = 1'b0;
    st_active_in    = 1'b0;
    sample_valid_in = 1'b0;
    sample_raw_in   = 16'h0000;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_factory();
    t_user();
    t_data();
    t_freeze();
    t_pcm();
    t_selftest();
    conclude();
  end
endmodule
